/* File: design/uotg_pkg.sv */
package uotg_pkg;
  localparam logic [11:0] UOTG_FLAGS_OFS   = 12'h000;
  localparam logic [11:0] UOTG_ENABLES_OFS = 12'h004;
  localparam logic [11:0] UOTG_STATUS_OFS  = 12'h008;
  localparam logic [11:0] UOTG_CONTROL_OFS = 12'h00c;
  localparam logic [7:0]  UOTG_FLAG_MASK   = 8'hfd;
  localparam logic [7:0]  UOTG_STAT_MASK   = 8'had;
  localparam logic [7:0]  UOTG_RESET_VAL   = 8'h00;
  localparam int          UOTG_CABLE_BIT   = 7;
  localparam int          UOTG_TIMER_BIT   = 6;
  localparam int          UOTG_LINE_BIT    = 5;
  localparam int          UOTG_WAKE_BIT    = 4;
  localparam int          UOTG_SVALID_BIT  = 3;
  localparam int          UOTG_SEND_BIT    = 2;
  localparam int          UOTG_ASUP_BIT    = 0;
  localparam int          UOTG_SWPULL_BIT  = 2;
  localparam int          UOTG_POWER_BIT   = 3;
  localparam int          UOTG_CHARGE_BIT  = 1;
  localparam int          UOTG_DISCH_BIT   = 0;
  localparam int          UOTG_CLK_MHZ     = 125;
  localparam int          UOTG_MS_US       = 1000;
  localparam int          UOTG_MS_CYCLES   = UOTG_CLK_MHZ * UOTG_MS_US;

  typedef struct packed {
    logic dplus_pullup_en;
    logic dminus_pullup_en;
    logic dplus_pulldown_en;
    logic dminus_pulldown_en;
  } uotg_pull_t;

  typedef struct packed {
    logic id_pin;
    logic se0;
    logic j_level_indicator;
    logic session_valid;
    logic session_end;
    logic a_supply_valid;
    logic wake_activity;
  } uotg_sense_t;
endpackage : uotg_pkg

/* File: design/uotg_regs.sv */
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
module uotg_regs
  import uotg_pkg::*;
#(
  parameter int MS_CYCLES = UOTG_MS_CYCLES
) (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Cable and comparator sense
  input  wire uotg_sense_t sense_i,
  // Pull resistors requested by the USB hardware
  input  wire uotg_pull_t  hw_pull_i,
  // Pull resistor and VBUS controls
  output uotg_pull_t       pull_o,
  output logic             bus_supply_power_en_o,
  output logic             bus_supply_charge_en_o,
  output logic             bus_supply_discharge_en_o,
  // Interrupt request
  output logic             irq_o
);
  localparam int CW = $clog2(MS_CYCLES + 1);

  logic [7:0]    flags_reg, flags_next;
  logic [7:0]    enables_reg;
  logic [7:0]    control_reg;
  logic [CW-1:0] timer_reg;
  logic [CW-1:0] line_cnt_reg;
  logic [1:0]    line_prev_reg;
  logic [1:0]    line_rec_reg;
  logic          line_steady_reg;
  logic          id_prev_reg;
  logic          svalid_prev_reg;
  logic          send_prev_reg;
  logic          asup_prev_reg;
  logic          sense_seen_reg;
  logic [31:0]   rdata_reg;

  wire           access   = psel_i & penable_i;
  wire           wr_en    = access & pwrite_i & pstrb_i[0];
  wire           hit_flg  = paddr_i == UOTG_FLAGS_OFS;
  wire           hit_en   = paddr_i == UOTG_ENABLES_OFS;
  wire           hit_stat = paddr_i == UOTG_STATUS_OFS;
  wire           hit_ctl  = paddr_i == UOTG_CONTROL_OFS;
  wire           mapped   = hit_flg | hit_en | hit_stat | hit_ctl;
  wire [1:0]     line_now = {sense_i.se0, sense_i.j_level_indicator};
  wire           timer_tick = timer_reg == CW'(MS_CYCLES - 1);
  wire           line_same  = line_now == line_prev_reg;
  wire           line_done  = line_same && (line_cnt_reg == CW'(MS_CYCLES - 1));
  wire           line_event = line_done && !line_steady_reg && (line_now != line_rec_reg);
  wire [7:0]     clr_mask   = (wr_en && hit_flg) ? pwdata_i[7:0] : 8'h00;
  wire [7:0]     set_mask;
  wire [7:0]     status_val;

  assign set_mask[UOTG_CABLE_BIT]  = sense_seen_reg && (sense_i.id_pin != id_prev_reg);
  assign set_mask[UOTG_TIMER_BIT]  = timer_tick;
  assign set_mask[UOTG_LINE_BIT]   = line_event;
  assign set_mask[UOTG_WAKE_BIT]   = sense_i.wake_activity;
  assign set_mask[UOTG_SVALID_BIT] = sense_seen_reg && svalid_prev_reg
                                     && !sense_i.session_valid;
  assign set_mask[UOTG_SEND_BIT]   = sense_seen_reg
                                     && (sense_i.session_end != send_prev_reg);
  assign set_mask[1]               = 1'b0;
  assign set_mask[UOTG_ASUP_BIT]   = sense_seen_reg
                                     && (sense_i.a_supply_valid != asup_prev_reg);

  // Set wins over a simultaneous clear
  assign flags_next = ((flags_reg & ~clr_mask) | set_mask) & UOTG_FLAG_MASK;

  assign status_val = {sense_i.id_pin, 1'b0, line_steady_reg, 1'b0,
                       sense_i.session_valid, sense_i.session_end, 1'b0,
                       sense_i.a_supply_valid};

  assign pull_o = control_reg[UOTG_SWPULL_BIT] ? uotg_pull_t'(control_reg[7:4])
                                               : hw_pull_i;
  assign bus_supply_power_en_o     = control_reg[UOTG_POWER_BIT];
  assign bus_supply_charge_en_o    = control_reg[UOTG_CHARGE_BIT];
  assign bus_supply_discharge_en_o = control_reg[UOTG_DISCH_BIT];
  assign irq_o     = |(flags_reg & enables_reg);
  assign pready_o  = 1'b1;
  assign pslverr_o = access & ~mapped;
  assign prdata_o  = rdata_reg;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flags_reg   <= UOTG_RESET_VAL;
      enables_reg <= UOTG_RESET_VAL;
      control_reg <= UOTG_RESET_VAL;
    end else begin
      flags_reg <= flags_next;
      if (wr_en && hit_en) begin
        enables_reg <= pwdata_i[7:0] & UOTG_FLAG_MASK;
      end
      if (wr_en && hit_ctl) begin
        control_reg <= pwdata_i[7:0];
      end
    end
  end

  // Read data registered at setup, ready in the access cycle
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_reg <= 32'h0000_0000;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      rdata_reg <= {24'h00_0000,
                    (hit_flg  ? flags_reg   : 8'h00) |
                    (hit_en   ? enables_reg : 8'h00) |
                    (hit_stat ? status_val  : 8'h00) |
                    (hit_ctl  ? control_reg : 8'h00)};
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      timer_reg <= '0;
    end else begin
      timer_reg <= timer_tick ? '0 : timer_reg + CW'(1);
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      line_cnt_reg    <= '0;
      line_prev_reg   <= 2'h0;
      line_rec_reg    <= 2'h0;
      line_steady_reg <= 1'b0;
    end else begin
      line_prev_reg <= line_now;
      if (!line_same) begin
        line_cnt_reg    <= '0;
        line_steady_reg <= 1'b0;
      end else if (line_done) begin
        line_steady_reg <= 1'b1;
        line_rec_reg    <= line_now;
      end else begin
        line_cnt_reg <= line_cnt_reg + CW'(1);
      end
    end
  end

  // Previous comparator levels; edges ignored until first sample
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      id_prev_reg     <= 1'b0;
      svalid_prev_reg <= 1'b0;
      send_prev_reg   <= 1'b0;
      asup_prev_reg   <= 1'b0;
      sense_seen_reg  <= 1'b0;
    end else begin
      id_prev_reg     <= sense_i.id_pin;
      svalid_prev_reg <= sense_i.session_valid;
      send_prev_reg   <= sense_i.session_end;
      asup_prev_reg   <= sense_i.a_supply_valid;
      sense_seen_reg  <= 1'b1;
    end
  end

  flag_clear_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (wr_en && hit_flg && pwdata_i[7] && !set_mask[7]) |=> !flags_reg[7])
    else $error("flag not cleared by write one");
  flag_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (flags_reg[7] && !(wr_en && hit_flg && pwdata_i[7])) |=> flags_reg[7])
    else $error("flag lost without clear");
  cable_change_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (sense_seen_reg && $changed(sense_i.id_pin)) |=> flags_reg[UOTG_CABLE_BIT])
    else $error("cable change flag not set");
  timer_flag_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    timer_tick |=> flags_reg[UOTG_TIMER_BIT] ##1 !timer_tick [*2])
    else $error("timer flag or period wrong");
  line_flag_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    line_event |=> flags_reg[UOTG_LINE_BIT] && line_steady_reg)
    else $error("line steady flag missing");
  svalid_fall_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (sense_seen_reg && $fell(sense_i.session_valid)) |=> flags_reg[UOTG_SVALID_BIT])
    else $error("session valid fall flag missing");
  bit1_zero_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !flags_reg[1] && !enables_reg[1])
    else $error("unimplemented bit set");
  pull_select_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    control_reg[UOTG_SWPULL_BIT] ? (pull_o == control_reg[7:4]) : (pull_o == hw_pull_i))
    else $error("pull source wrong");
  upper_zero_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    prdata_o[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  irq_level_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    irq_o == |(flags_reg & enables_reg))
    else $error("irq does not match flags");
  wake_flag_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    sense_i.wake_activity |=> flags_reg[UOTG_WAKE_BIT])
    else $error("wake activity flag missing");
  send_change_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (sense_seen_reg && $changed(sense_i.session_end)) |=> flags_reg[UOTG_SEND_BIT])
    else $error("session end change flag missing");
  asup_change_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (sense_seen_reg && $changed(sense_i.a_supply_valid)) |=> flags_reg[UOTG_ASUP_BIT])
    else $error("a supply change flag missing");
  enable_write_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (wr_en && hit_en) |=> (enables_reg == (8'($past(pwdata_i)) & UOTG_FLAG_MASK)))
    else $error("enable write not taken");
  read_status_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (psel_i && !penable_i && !pwrite_i && hit_stat) |=>
      (prdata_o[UOTG_CABLE_BIT] == $past(sense_i.id_pin))
      && (prdata_o[UOTG_SVALID_BIT] == $past(sense_i.session_valid))
      && (prdata_o[UOTG_ASUP_BIT] == $past(sense_i.a_supply_valid)))
    else $error("status read does not follow pins");
  status_gaps_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (psel_i && !penable_i && !pwrite_i && hit_stat) |=>
      !(prdata_o[6] || prdata_o[4] || prdata_o[1]))
    else $error("unimplemented status bit set");
  line_status_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !line_same |=> !line_steady_reg)
    else $error("line steady status kept after change");
  power_on_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (wr_en && hit_ctl && pwdata_i[UOTG_POWER_BIT]) |=> bus_supply_power_en_o)
    else $error("supply power output not raised");
  charge_off_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (wr_en && hit_ctl && !pwdata_i[UOTG_CHARGE_BIT]) |=> !bus_supply_charge_en_o)
    else $error("charge output not removed");
  discharge_on_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (wr_en && hit_ctl && pwdata_i[UOTG_DISCH_BIT]) |=> bus_supply_discharge_en_o)
    else $error("discharge output not raised");
endmodule : uotg_regs

/* File: sim/uotg_cable_model.sv */
`timescale 1ns/1ps
module uotg_cable_model
  import uotg_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_n_i,
  // Cable state asked for by the bench
  input  wire logic       id_i,
  input  wire logic       vbus_i,
  input  wire logic [1:0] line_i,
  input  wire logic       wake_i,
  // Pin and comparator sense
  output uotg_sense_t     sense_o
);
  // Idle cable: no plug, VBUS low, so session end is high
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sense_o <= 7'h44;
    end else begin
      sense_o <= {id_i, line_i, vbus_i, !vbus_i, vbus_i, wake_i};
    end
  end
endmodule : uotg_cable_model

/* File: sim/uotg_regs_tb.sv */
`timescale 1ns/1ps
module uotg_regs_tb;
  import uotg_pkg::*;
  localparam int MS = 50;
  logic        core_clk, rst_n, psel, penable, pwrite, pready, pslverr, irq;
  logic        id, vbus, wake, pwr, chg, dis;
  logic [1:0]  line;
  logic [3:0]  pstrb, hw;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, d, seed;
  uotg_sense_t sense;
  uotg_pull_t  hw_pull, pull;
  int          error_cnt, checks;

  uotg_regs #(.MS_CYCLES(MS)) uotg_regs_i (.core_clk_i(core_clk), .rst_n_i(rst_n),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .sense_i(sense), .hw_pull_i(hw_pull), .pull_o(pull),
    .bus_supply_power_en_o(pwr), .bus_supply_charge_en_o(chg),
    .bus_supply_discharge_en_o(dis), .irq_o(irq));
  uotg_cable_model uotg_cable_model_i (.core_clk_i(core_clk), .rst_n_i(rst_n), .id_i(id),
    .vbus_i(vbus), .line_i(line), .wake_i(wake), .sense_o(sense));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc

  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
           output logic [31:0] r, output logic e);
    @(posedge core_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, wd};
    pstrb <= {4{w}};
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [11:0] a, input logic [31:0] wd);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, wd, r, e);
  endtask : wr

  task rd(input logic [11:0] a, input logic [7:0] m, input logic [7:0] x, input logic err);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    checks++;
    if ((r & {24'hffffff, m}) !== {24'h0, x & m} || e !== err) begin
      error_cnt++;
      $display("ERROR reg %h expected %h/%b seen %h/%b", a, x & m, err, r, e);
    end
  endtask : rd

  task chk(input string n, input logic [7:0] x, input logic [7:0] g);
    checks++;
    if (g !== x) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, x, g);
    end
  endtask : chk

  function automatic logic [7:0] exp_pull(input logic [31:0] c, input logic [3:0] h);
    return {4'h0, c[UOTG_SWPULL_BIT] ? c[7:4] : h};
  endfunction : exp_pull

  task give_verdict;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  initial begin
    #100000;
    error_cnt++;
    give_verdict();
  end

  initial begin
    seed = 32'h0cb19a2e;
    {rst_n, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {vbus, wake, line, hw_pull, error_cnt, checks} = '0;
    id = 1'b1;
    cyc(3);
    rst_n <= 1'b1;
    rd(UOTG_ENABLES_OFS, 8'hff, 8'h00, 1'b0);
    rd(UOTG_CONTROL_OFS, 8'hff, 8'h00, 1'b0);
    rd(UOTG_STATUS_OFS, 8'hdf, 8'h84, 1'b0);
    rd(UOTG_FLAGS_OFS, 8'hbf, 8'h00, 1'b0);
    rd(12'h010, 8'hff, 8'h00, 1'b1);
    for (int i = 0; i < 10; i++) begin
      d = (i == 0) ? 32'hffffffff : (i == 1) ? 32'h0 : $random(seed);
      hw = 4'($random(seed));
      hw_pull <= hw;
      wr(UOTG_ENABLES_OFS, d);
      rd(UOTG_ENABLES_OFS, 8'hff, d[7:0] & UOTG_FLAG_MASK, 1'b0);
      wr(UOTG_CONTROL_OFS, d);
      rd(UOTG_CONTROL_OFS, 8'hff, d[7:0], 1'b0);
      chk("pull", exp_pull(d, hw), {4'h0, pull});
      chk("supply", {5'h0, d[3], d[1], d[0]}, {5'h0, pwr, chg, dis});
    end
    wr(UOTG_ENABLES_OFS, 32'h0);
    wr(UOTG_FLAGS_OFS, 32'hff);
    id <= 1'b0;
    cyc(4);
    rd(UOTG_FLAGS_OFS, 8'h80, 8'h80, 1'b0);
    rd(UOTG_STATUS_OFS, 8'h80, 8'h00, 1'b0);
    wr(UOTG_FLAGS_OFS, 32'h0);
    rd(UOTG_FLAGS_OFS, 8'h80, 8'h80, 1'b0);
    wr(UOTG_FLAGS_OFS, 32'h80);
    rd(UOTG_FLAGS_OFS, 8'h80, 8'h00, 1'b0);
    // Rising VBUS must not raise the session valid flag
    wr(UOTG_FLAGS_OFS, 32'hff);
    vbus <= 1'b1;
    cyc(4);
    rd(UOTG_FLAGS_OFS, 8'h0f, 8'h05, 1'b0);
    rd(UOTG_STATUS_OFS, 8'h0f, 8'h09, 1'b0);
    wr(UOTG_FLAGS_OFS, 32'hff);
    vbus <= 1'b0;
    cyc(4);
    rd(UOTG_FLAGS_OFS, 8'h0f, 8'h0d, 1'b0);
    rd(UOTG_STATUS_OFS, 8'h0f, 8'h04, 1'b0);
    wake <= 1'b1;
    cyc(1);
    wake <= 1'b0;
    cyc(3);
    rd(UOTG_FLAGS_OFS, 8'h10, 8'h10, 1'b0);
    wr(UOTG_ENABLES_OFS, 32'h40);
    wr(UOTG_FLAGS_OFS, 32'h40);
    cyc(MS + 2);
    rd(UOTG_FLAGS_OFS, 8'h40, 8'h40, 1'b0);
    chk("irq", 8'h01, {7'h0, irq});
    wr(UOTG_ENABLES_OFS, 32'h0);
    cyc(1);
    chk("irq", 8'h00, {7'h0, irq});
    line <= 2'b01;
    cyc(4);
    rd(UOTG_STATUS_OFS, 8'h20, 8'h00, 1'b0);
    wr(UOTG_FLAGS_OFS, 32'h20);
    cyc(MS + 4);
    rd(UOTG_STATUS_OFS, 8'h20, 8'h20, 1'b0);
    rd(UOTG_FLAGS_OFS, 8'h20, 8'h20, 1'b0);
    // Short glitch, then back to the recorded stable value
    wr(UOTG_FLAGS_OFS, 32'h20);
    line <= 2'b10;
    cyc(5);
    line <= 2'b01;
    cyc(MS + 4);
    rd(UOTG_FLAGS_OFS, 8'h20, 8'h00, 1'b0);
    // Reset in mid-run with the cable at its idle levels
    id   <= 1'b1;
    line <= 2'b00;
    wr(UOTG_ENABLES_OFS, 32'hff);
    wr(UOTG_CONTROL_OFS, 32'hff);
    rst_n <= 1'b0;
    cyc(2);
    rst_n <= 1'b1;
    chk("irq", 8'h00, {7'h0, irq});
    chk("supply", 8'h00, {5'h0, pwr, chg, dis});
    rd(UOTG_ENABLES_OFS, 8'hff, 8'h00, 1'b0);
    rd(UOTG_CONTROL_OFS, 8'hff, 8'h00, 1'b0);
    rd(UOTG_FLAGS_OFS, 8'hbf, 8'h00, 1'b0);
    give_verdict();
  end
endmodule : uotg_regs_tb
